/* design/uifc_pkg.sv */
/*
 * Package of the serial-port interrupt and FIFO control block: register
 * indices, field positions, identifier codes and the bus and datapath carriers.
 * Assumes a 32-bit classic Wishbone bus with register data in byte lane 0.
 */
package uifc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [2:0] IDX_DATA       = 3'h0;
    localparam logic [2:0] IDX_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] IDX_FIFO_IDENT = 3'h2;
    localparam logic [2:0] IDX_LINE_CTRL  = 3'h3;
    localparam logic [2:0] IDX_MODEM_CTRL = 3'h4;
    localparam logic [2:0] IDX_LINE_STATE = 3'h5;
    localparam logic [2:0] IDX_MODEM_STAT = 3'h6;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IE_RX_AVAIL   = 0;
    localparam int IE_TX_EMPTY   = 1;
    localparam int IE_LINE_ERR   = 2;
    localparam int IE_MODEM_CHG  = 3;
    localparam int FC_MODE_ON    = 0;
    localparam int FC_RX_FLUSH   = 1;
    localparam int FC_TX_FLUSH   = 2;
    localparam int FC_DMA_SEL    = 3;
    localparam int FC_TRIG_LO    = 6;
    localparam int FC_TRIG_HI    = 7;
    localparam int LC_DIV_ACCESS = 7;
    localparam int MC_OUT2       = 3;

    // ------------------------------------------------------------------
    // Reset values, levels and counts
    // ------------------------------------------------------------------
    localparam logic [3:0] IRQ_EN_RESET  = 4'h0;
    localparam logic [1:0] TRIG_RESET    = 2'h0;
    localparam logic [7:0] DIVISOR_RESET = 8'h00;
    localparam logic [4:0] TRIG_LEVEL_0  = 5'h01;
    localparam logic [4:0] TRIG_LEVEL_1  = 5'h04;
    localparam logic [4:0] TRIG_LEVEL_2  = 5'h08;
    localparam logic [4:0] TRIG_LEVEL_3  = 5'h0E;
    localparam logic [4:0] FIFO_DEPTH    = 5'h10;
    localparam logic [2:0] CHAR_TIMEOUT  = 3'h4;

    // ------------------------------------------------------------------
    // Identifier codes, bits 3 to 0
    // ------------------------------------------------------------------
    localparam logic [3:0] IID_NONE    = 4'h1;
    localparam logic [3:0] IID_LINE    = 4'h6;
    localparam logic [3:0] IID_RX_DATA = 4'h4;
    localparam logic [3:0] IID_TIMEOUT = 4'hC;
    localparam logic [3:0] IID_TX_EMPT = 4'h2;
    localparam logic [3:0] IID_MODEM   = 4'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [4:2]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } uifc_wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } uifc_wb_rsp_type;

    typedef struct packed {
        logic [4:0] rxCount;
        logic [4:0] txCount;
        logic       rxDataReady;
        logic       txHoldingEmpty;
        logic [3:0] lineErr;
        logic [3:0] modemDelta;
        logic       charTick;
        logic       rxActivity;
        logic [7:0] rxData;
        logic [7:0] lineStateReg;
        logic [7:0] modemStateReg;
    } uifc_stat_type;

    typedef struct packed {
        logic        rxFlush;
        logic        txFlush;
        logic        rxRead;
        logic        txWrite;
        logic        lineRead;
        logic        modemRead;
        logic [7:0]  txData;
        logic [15:0] divisor;
    } uifc_ctl_type;

endpackage : uifc_pkg

/* design/uifc_core.sv */
/*
 * Interrupt enable, FIFO control and interrupt identification of a serial
 * port, with a classic Wishbone register slave and the DMA request pins.
 * Assumes the receive/transmit datapath runs on the same clock and reports
 * FIFO counts, status bits and a one-cycle pulse per character time.
 */
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps

module uifc_core
    import uifc_pkg::*;
(
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst_b,
    // Register bus
    input  wire uifc_wb_req_type wbReq,
    output uifc_wb_rsp_type      wbRsp,
    // Datapath status and control
    input  wire uifc_stat_type   stat,
    output uifc_ctl_type         ctl,
    // Pins
    output logic                 hostIrqOut,
    output logic                 hostIrqOutEn_b,
    output logic                 rxDmaRequest,
    output logic                 txDmaRequest
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic         ack;
        logic [7:0]   rdData;
        logic [3:0]   irqEn;
        logic         fifoModeOn;
        logic         dmaSel;
        logic [1:0]   trigSel;
        logic         divAccessSel;
        logic         out2;
        logic [15:0]  divisor;
        logic         lineIrq;
        logic         txIrq;
        logic         timeoutIrq;
        logic [2:0]   tickCnt;
        logic [3:0]   prevErr;
        logic         prevEmpty;
        logic         irqOut;
        logic         irqOutEn_b;
        logic         rxReq;
        logic         txReq;
        uifc_ctl_type ctl;
    } uifc_state_type;

    uifc_state_type st_q;
    uifc_state_type st_d;

    logic       access;
    logic       isRead;
    logic       isWrite;
    logic       lane0;
    logic [7:0] wrByte;
    logic [4:0] trigLevel;
    logic       rxAboveTrig;
    logic       linePend;
    logic       rxPend;
    logic       timeoutPend;
    logic       txPend;
    logic       modemPend;
    logic       anyPend;
    logic [3:0] iid;

    // ------------------------------------------------------------------
    // Bus decode and identifier
    // ------------------------------------------------------------------
    assign access  = wbReq.cyc & wbReq.stb & ~st_q.ack;
    assign isRead  = access & ~wbReq.we;
    assign lane0   = wbReq.sel[0];
    assign isWrite = access & wbReq.we & lane0;
    assign wrByte  = wbReq.dat[7:0];

    always_comb begin
        unique case (st_q.trigSel)
            2'b00: trigLevel = TRIG_LEVEL_0;
            2'b01: trigLevel = TRIG_LEVEL_1;
            2'b10: trigLevel = TRIG_LEVEL_2;
            2'b11: trigLevel = TRIG_LEVEL_3;
        endcase
    end

    assign rxAboveTrig = stat.rxCount >= trigLevel;

    // Pending terms are gated by their enables
    assign linePend    = st_q.irqEn[IE_LINE_ERR] & st_q.lineIrq;
    assign rxPend      = st_q.irqEn[IE_RX_AVAIL]
                         & (st_q.fifoModeOn ? rxAboveTrig : stat.rxDataReady);
    assign timeoutPend = st_q.irqEn[IE_RX_AVAIL] & st_q.fifoModeOn
                         & st_q.timeoutIrq;
    assign txPend      = st_q.irqEn[IE_TX_EMPTY] & st_q.txIrq;
    assign modemPend   = st_q.irqEn[IE_MODEM_CHG] & (|stat.modemDelta);
    assign anyPend     = linePend | rxPend | timeoutPend | txPend | modemPend;

    always_comb begin
        if (linePend) begin
            iid = IID_LINE;
        end else if (rxPend) begin
            iid = IID_RX_DATA;
        end else if (timeoutPend) begin
            iid = IID_TIMEOUT;
        end else if (txPend) begin
            iid = IID_TX_EMPT;
        end else if (modemPend) begin
            iid = IID_MODEM;
        end else begin
            iid = IID_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d             = st_q;
        st_d.ack         = access;
        st_d.ctl.rxFlush = 1'b0;
        st_d.ctl.txFlush = 1'b0;
        st_d.ctl.rxRead  = 1'b0;
        st_d.ctl.txWrite = 1'b0;
        st_d.ctl.lineRead  = 1'b0;
        st_d.ctl.modemRead = 1'b0;
        st_d.prevErr     = stat.lineErr;
        st_d.prevEmpty   = stat.txHoldingEmpty;

        // Read data is captured once, so the identifier cannot move mid access
        if (isRead) begin
            unique case (wbReq.adr)
                IDX_DATA: begin
                    st_d.rdData     = st_q.divAccessSel ? st_q.divisor[7:0]
                                                        : stat.rxData;
                    st_d.ctl.rxRead = ~st_q.divAccessSel;
                end
                IDX_IRQ_ENABLE: begin
                    st_d.rdData = st_q.divAccessSel ? st_q.divisor[15:8]
                                                    : {4'h0, st_q.irqEn};
                end
                IDX_FIFO_IDENT: begin
                    st_d.rdData = {st_q.fifoModeOn, st_q.fifoModeOn,
                                   2'b00, iid};
                end
                IDX_LINE_CTRL: begin
                    st_d.rdData = {st_q.divAccessSel, 7'h00};
                end
                IDX_MODEM_CTRL: begin
                    st_d.rdData = {4'h0, st_q.out2, 3'h0};
                end
                IDX_LINE_STATE: begin
                    st_d.rdData       = stat.lineStateReg;
                    st_d.ctl.lineRead = 1'b1;
                end
                IDX_MODEM_STAT: begin
                    st_d.rdData        = stat.modemStateReg;
                    st_d.ctl.modemRead = 1'b1;
                end
                default: begin
                    st_d.rdData = 8'h00;
                end
            endcase
        end

        if (isWrite) begin
            unique case (wbReq.adr)
                IDX_DATA: begin
                    if (st_q.divAccessSel) begin
                        st_d.divisor[7:0] = wrByte;
                    end else begin
                        st_d.ctl.txWrite = 1'b1;
                        st_d.ctl.txData  = wrByte;
                    end
                end
                IDX_IRQ_ENABLE: begin
                    if (st_q.divAccessSel) begin
                        st_d.divisor[15:8] = wrByte;
                    end else begin
                        st_d.irqEn = wrByte[3:0];
                    end
                end
                IDX_FIFO_IDENT: begin
                    st_d.fifoModeOn = wrByte[FC_MODE_ON];
                    if (wrByte[FC_MODE_ON]) begin
                        st_d.trigSel     = wrByte[FC_TRIG_HI:FC_TRIG_LO];
                        st_d.dmaSel      = wrByte[FC_DMA_SEL];
                        st_d.ctl.rxFlush = wrByte[FC_RX_FLUSH];
                        st_d.ctl.txFlush = wrByte[FC_TX_FLUSH];
                    end else begin
                        st_d.ctl.rxFlush = 1'b1;
                        st_d.ctl.txFlush = 1'b1;
                    end
                end
                IDX_LINE_CTRL: begin
                    st_d.divAccessSel = wrByte[LC_DIV_ACCESS];
                end
                IDX_MODEM_CTRL: begin
                    st_d.out2 = wrByte[MC_OUT2];
                end
                default: begin
                end
            endcase
        end

        // Line error interrupt: set on any change while enabled, cleared by status read
        if (isRead && wbReq.adr == IDX_LINE_STATE) begin
            st_d.lineIrq = 1'b0;
        end
        if (st_q.irqEn[IE_LINE_ERR] && stat.lineErr != st_q.prevErr) begin
            st_d.lineIrq = 1'b1;
        end

        // Transmit empty interrupt: cleared by an identifier read that shows it, or by a data write
        if ((isRead && wbReq.adr == IDX_FIFO_IDENT && iid == IID_TX_EMPT)
            || (isWrite && wbReq.adr == IDX_DATA && !st_q.divAccessSel)) begin
            st_d.txIrq = 1'b0;
        end
        if (st_q.irqEn[IE_TX_EMPTY] && stat.txHoldingEmpty
            && (!st_q.prevEmpty || !st_q.txIrq && isWrite
                && wbReq.adr == IDX_IRQ_ENABLE && !st_q.irqEn[IE_TX_EMPTY])) begin
            st_d.txIrq = 1'b1;
        end
        if (isWrite && wbReq.adr == IDX_IRQ_ENABLE && !st_q.divAccessSel
            && wrByte[IE_TX_EMPTY] && !st_q.irqEn[IE_TX_EMPTY]
            && stat.txHoldingEmpty) begin
            st_d.txIrq = 1'b1;
        end

        // Character timeout: count idle character times with data waiting
        if (!st_q.fifoModeOn || stat.rxCount == 5'h00 || stat.rxActivity
            || st_d.ctl.rxRead) begin
            st_d.tickCnt = 3'h0;
        end else if (stat.charTick && st_q.tickCnt != CHAR_TIMEOUT) begin
            st_d.tickCnt = st_q.tickCnt + 3'h1;
        end
        if (st_d.ctl.rxRead || !st_q.fifoModeOn) begin
            st_d.timeoutIrq = 1'b0;
        end
        if (st_q.fifoModeOn && st_q.tickCnt == CHAR_TIMEOUT
            && stat.rxCount != 5'h00 && !stat.rxActivity && !st_d.ctl.rxRead) begin
            st_d.timeoutIrq = 1'b1;
        end

        // Host interrupt pin, released while output two is low
        st_d.irqOut     = anyPend;
        st_d.irqOutEn_b = ~st_q.out2;

        // DMA request pins
        if (st_q.fifoModeOn && st_q.dmaSel) begin
            if (rxAboveTrig || st_q.timeoutIrq) begin
                st_d.rxReq = 1'b1;
            end else if (stat.rxCount == 5'h00) begin
                st_d.rxReq = 1'b0;
            end
            st_d.txReq = stat.txCount != FIFO_DEPTH;
        end else if (st_q.fifoModeOn) begin
            st_d.rxReq = stat.rxCount != 5'h00;
            st_d.txReq = stat.txCount == 5'h00;
        end else begin
            st_d.rxReq = stat.rxDataReady;
            st_d.txReq = stat.txHoldingEmpty;
        end
        st_d.ctl.divisor = st_d.divisor;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q            <= '0;
            st_q.irqEn      <= IRQ_EN_RESET;
            st_q.trigSel    <= TRIG_RESET;
            st_q.divisor    <= {DIVISOR_RESET, DIVISOR_RESET};
            st_q.ctl.divisor <= {DIVISOR_RESET, DIVISOR_RESET};
            st_q.irqOutEn_b <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign wbRsp.ack      = st_q.ack;
    assign wbRsp.dat      = {24'h000000, st_q.rdData};
    assign ctl            = st_q.ctl;
    assign hostIrqOut     = st_q.irqOut;
    assign hostIrqOutEn_b = st_q.irqOutEn_b;
    assign rxDmaRequest   = st_q.rxReq;
    assign txDmaRequest   = st_q.txReq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    chk_irq_all_off: assert property (
        st_q.irqEn == 4'h0 |=> !hostIrqOut)
        else $error("interrupt raised with all sources disabled");

    chk_modem_irq_on: assert property (
        st_q.irqEn[IE_MODEM_CHG] && (|stat.modemDelta) |=> hostIrqOut)
        else $error("modem change did not raise interrupt");

    chk_line_err_set: assert property (
        st_q.irqEn[IE_LINE_ERR] && stat.lineErr != st_q.prevErr
        |=> st_q.lineIrq [*1] ##1 hostIrqOut || st_q.lineIrq == 1'b0)
        else $error("line error change lost");

    chk_tx_empty_rise: assert property (
        st_q.irqEn[IE_TX_EMPTY] && stat.txHoldingEmpty && !st_q.prevEmpty
        |=> st_q.txIrq)
        else $error("transmit empty edge did not flag");

    chk_trig_fourteen: assert property (
        st_q.fifoModeOn && st_q.trigSel == 2'b11 && stat.rxCount == 5'h0D
        && st_q.irqEn == 4'h1 && !st_q.timeoutIrq |=> !hostIrqOut)
        else $error("receive trigger fired below fourteen");

    chk_dma_tx_full: assert property (
        st_q.fifoModeOn && st_q.dmaSel && stat.txCount == FIFO_DEPTH
        |=> !txDmaRequest)
        else $error("transmit request with full FIFO");

    chk_dma_rx_empty: assert property (
        st_q.fifoModeOn && st_q.dmaSel && stat.rxCount == 5'h00 && !st_q.timeoutIrq
        |=> !rxDmaRequest)
        else $error("receive request with empty FIFO");

    chk_timeout_read_clear: assert property (
        isRead && wbReq.adr == IDX_DATA && !st_q.divAccessSel |=> !st_q.timeoutIrq)
        else $error("character timeout survived a data read");

    chk_tx_flush_pulse: assert property (
        isWrite && wbReq.adr == IDX_FIFO_IDENT && wrByte[FC_MODE_ON]
        && wrByte[FC_TX_FLUSH] |=> ctl.txFlush ##1 !ctl.txFlush)
        else $error("transmit flush not a single pulse");

    chk_ident_top_bits: assert property (
        isRead && wbReq.adr == IDX_FIFO_IDENT
        |=> wbRsp.ack && wbRsp.dat[7:4] == {$past(st_q.fifoModeOn),
                                            $past(st_q.fifoModeOn), 2'b00})
        else $error("identifier top bits wrong");

    chk_pin_float: assert property (
        !st_q.out2 |=> hostIrqOutEn_b)
        else $error("interrupt pin driven while output two low");

endmodule : uifc_core

/* testbench/uifc_dpath_model.sv */
/*
 * Behavioural stand-in for the receive and transmit FIFO datapath.
 * Assumes the same clock as uifc_core; the transmitter never drains.
 */
`timescale 1ns/100ps

module uifc_dpath_model
    import uifc_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst_b,
    // Block control
    input  wire uifc_ctl_type  ctl,
    // Bench stimulus
    input  wire logic          rxPush,
    input  wire logic          tickOn,
    input  wire logic [3:0]    lineErr,
    input  wire logic [3:0]    modemSet,
    // Status to the block
    output uifc_stat_type      stat
);
    logic [4:0] rxCnt_q;
    logic [4:0] txCnt_q;
    logic [3:0] delta_q;
    logic [1:0] tick_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxCnt_q <= 5'h00;
            txCnt_q <= 5'h00;
            delta_q <= 4'h0;
            tick_q  <= 2'h0;
        end else begin
            // Flush wins over push and pop
            if (ctl.rxFlush)
                rxCnt_q <= 5'h00;
            else
                rxCnt_q <= rxCnt_q + 5'((rxPush && rxCnt_q < FIFO_DEPTH))
                           - 5'((ctl.rxRead && rxCnt_q != 5'h00));
            if (ctl.txFlush)
                txCnt_q <= 5'h00;
            else if (ctl.txWrite && txCnt_q < FIFO_DEPTH)
                txCnt_q <= txCnt_q + 5'h01;
            delta_q <= ctl.modemRead ? 4'h0 : (delta_q | modemSet);
            tick_q  <= tickOn ? tick_q + 2'h1 : 2'h0;
        end
    end

    always_comb begin
        stat                = '0;
        stat.rxCount        = rxCnt_q;
        stat.txCount        = txCnt_q;
        stat.rxDataReady    = (rxCnt_q != 5'h00);
        stat.txHoldingEmpty = (txCnt_q == 5'h00);
        stat.lineErr        = lineErr;
        stat.modemDelta     = delta_q;
        stat.charTick       = tickOn && (tick_q == 2'h3);
        stat.rxActivity     = rxPush || ctl.rxRead;
        stat.rxData         = 8'hA5;
        stat.lineStateReg   = {3'h0, lineErr, 1'h0};
        stat.modemStateReg  = {4'h0, delta_q};
    end
endmodule : uifc_dpath_model

/* testbench/uifc_core_tb.sv */
/*
 * Self-checking bench of uifc_core over classic Wishbone.
 * Assumes uifc_dpath_model stands in for the FIFO datapath.
 */
`timescale 1ns/100ps

module uifc_core_tb;
    import uifc_pkg::*;
    logic            clock;
    logic            rst_b;
    uifc_wb_req_type wbReq;
    uifc_wb_rsp_type wbRsp;
    uifc_stat_type   stat;
    uifc_ctl_type    ctl;
    logic            hostIrqOut;
    logic            hostIrqOutEn_b;
    logic            rxDmaRequest;
    logic            txDmaRequest;
    logic            rxPush;
    logic            tickOn;
    logic [3:0]      lineErr;
    logic [3:0]      modemSet;
    logic [7:0]      rd;
    logic [4:0]      lvl [4];
    int              fail_count;
    int              compares;

    uifc_core u_dut (.clock(clock), .rst_b(rst_b), .wbReq(wbReq), .wbRsp(wbRsp),
        .stat(stat), .ctl(ctl), .hostIrqOut(hostIrqOut), .hostIrqOutEn_b(hostIrqOutEn_b),
        .rxDmaRequest(rxDmaRequest), .txDmaRequest(txDmaRequest));
    uifc_dpath_model u_dpath (.clock(clock), .rst_b(rst_b), .ctl(ctl), .rxPush(rxPush),
        .tickOn(tickOn), .lineErr(lineErr), .modemSet(modemSet), .stat(stat));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [2:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        wbReq <= '{cyc:1'h1, stb:1'h1, we:we, adr:idx, sel:4'h1, dat:{24'h0, wd}};
        do begin
            @(posedge clock);
            n++;
        end while (wbRsp.ack !== 1'h1 && n < 20);
        if (n >= 20) fail_count++;
        rd = wbRsp.dat[7:0];
        wbReq <= '0;
        @(posedge clock);
    endtask : wb

    task automatic rdc(input string nm, input logic [2:0] idx, input logic [7:0] exp);
        wb(1'h0, idx, 8'h00);
        chk(nm, rd, exp);
    endtask : rdc

    task automatic push(input int n);
        if (n > 0) begin
            rxPush <= 1'h1;
            repeat (n) @(posedge clock);
            rxPush <= 1'h0;
        end
        repeat (2) @(posedge clock);
    endtask : push

    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    initial begin
        #(100 * 5000);
        fail_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        lvl = '{TRIG_LEVEL_0, TRIG_LEVEL_1, TRIG_LEVEL_2, TRIG_LEVEL_3};
        rst_b = 1'h0; wbReq = '0; rxPush = 1'h0; tickOn = 1'h0;
        lineErr = 4'h0; modemSet = 4'h0; fail_count = 0; compares = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        rdc("identifier", IDX_FIFO_IDENT, 8'h01);
        rdc("irq enable", IDX_IRQ_ENABLE, 8'h00);
        chk("pin float", 8'(hostIrqOutEn_b), 8'h01);
        $display("test reset done");

        wb(1'h1, IDX_MODEM_CTRL, 8'h08);
        modemSet <= 4'h1;
        @(posedge clock);
        modemSet <= 4'h0;
        push(0);
        chk("pin driven", 8'(hostIrqOutEn_b), 8'h00);
        chk("irq masked", 8'(hostIrqOut), 8'h00);
        rdc("identifier", IDX_FIFO_IDENT, 8'h01);
        wb(1'h1, IDX_IRQ_ENABLE, 8'h08);
        push(0);
        chk("irq modem", 8'(hostIrqOut), 8'h01);
        rdc("identifier", IDX_FIFO_IDENT, 8'h00);
        rdc("modem status", IDX_MODEM_STAT, 8'h01);
        rdc("identifier", IDX_FIFO_IDENT, 8'h01);
        wb(1'h1, IDX_LINE_CTRL, 8'h80);
        wb(1'h1, IDX_IRQ_ENABLE, 8'h0F);
        wb(1'h1, IDX_LINE_CTRL, 8'h00);
        rdc("irq enable", IDX_IRQ_ENABLE, 8'h08);
        chk("divisor high", ctl.divisor[15:8], 8'h0F);
        $display("test modem done");

        wb(1'h1, IDX_IRQ_ENABLE, 8'h01);
        for (int t = 0; t < 4; t++) begin
            wb(1'h1, IDX_FIFO_IDENT, {2'(t), 6'h03});
            push(int'(lvl[t]) - 1);
            chk("below trigger", 8'(hostIrqOut), 8'h00);
            rdc("identifier", IDX_FIFO_IDENT, 8'hC1);
            push(1);
            chk("at trigger", 8'(hostIrqOut), 8'h01);
            rdc("identifier", IDX_FIFO_IDENT, 8'hC4);
        end
        wb(1'h1, IDX_FIFO_IDENT, 8'hC3);
        push(0);
        rdc("identifier", IDX_FIFO_IDENT, 8'hC1);
        push(1);
        tickOn <= 1'h1;
        repeat (40) @(posedge clock);
        rdc("identifier", IDX_FIFO_IDENT, 8'hCC);
        tickOn <= 1'h0;
        rdc("receive data", IDX_DATA, 8'hA5);
        push(0);
        rdc("identifier", IDX_FIFO_IDENT, 8'hC1);
        $display("test trigger done");

        chk("rx request empty", 8'(rxDmaRequest), 8'h00);
        chk("tx request empty", 8'(txDmaRequest), 8'h01);
        push(1);
        chk("rx request one", 8'(rxDmaRequest), 8'h01);
        wb(1'h1, IDX_DATA, 8'h55);
        chk("tx data", ctl.txData, 8'h55);
        push(0);
        chk("tx request loaded", 8'(txDmaRequest), 8'h00);
        wb(1'h1, IDX_FIFO_IDENT, 8'h0B);
        push(0);
        chk("dma rx flushed", 8'(rxDmaRequest), 8'h00);
        chk("dma tx room", 8'(txDmaRequest), 8'h01);
        repeat (15) wb(1'h1, IDX_DATA, 8'h3C);
        push(0);
        chk("dma tx full", 8'(txDmaRequest), 8'h00);
        wb(1'h1, IDX_FIFO_IDENT, 8'h0D);
        push(0);
        chk("tx flushed", 8'(txDmaRequest), 8'h01);
        $display("test dma done");

        wb(1'h1, IDX_IRQ_ENABLE, 8'h06);
        push(0);
        chk("irq tx empty", 8'(hostIrqOut), 8'h01);
        lineErr <= 4'h2;
        push(0);
        rdc("identifier", IDX_FIFO_IDENT, 8'hC6);
        rdc("line status", IDX_LINE_STATE, 8'h04);
        rdc("identifier", IDX_FIFO_IDENT, 8'hC2);
        rdc("identifier", IDX_FIFO_IDENT, 8'hC1);
        wb(1'h1, IDX_FIFO_IDENT, 8'h00);
        rdc("identifier", IDX_FIFO_IDENT, 8'h01);
        wb(1'h1, IDX_FIFO_IDENT, 8'hC8);
        rdc("identifier", IDX_FIFO_IDENT, 8'h01);
        wb(1'h1, IDX_DATA, 8'h11);
        push(0);
        chk("dma ignored", 8'(txDmaRequest), 8'h00);
        $display("test priority done");
        report_and_stop();
    end
endmodule : uifc_core_tb
